/* common/card_mgr_cfg.svh */
// Timing, limits and reset values for the card manager
`ifndef CARD_MGR_CFG_SVH
`define CARD_MGR_CFG_SVH

`define CLK_HZ 25000000
`define TICK_MS 100
`define PWRUP_MS 3000
`define RESUME_MS 10000
`define EJECT_FLASH_MS 2000
`define IDLE_FRAME_MS 3000
`define BLINK_FRAME_TICKS 10
`define SLOW_ON_TICKS 5
`define ACK_TICKS 4
`define ROOT_MAX_ENTRIES 512
`define FAT16_MAX_SECTORS 32'h0080_0000
`define CLUSTER_MAX_SECTORS 8'h80
`define SECTORS_RESET 32'h0000_0000

`endif

/* common/card_mgr_pkg.sv */
// Types shared by the card manager, the card controller model and the bench
`default_nettype none
package card_mgr_pkg;

  typedef enum logic [3:0] {
    ST_PWRUP, ST_NOCARD, ST_FMT_ACK, ST_FMT_REL, ST_FORMAT, ST_FMT_FAIL,
    ST_INIT, ST_INIT_FAIL, ST_READY, ST_EJECT_CLOSE, ST_EJECTED
  } state_t;

  typedef enum logic [1:0] {
    CMD_NONE, CMD_INIT, CMD_FORMAT, CMD_CLOSE
  } cmd_t;

  typedef enum logic [2:0] {
    FAIL_NONE, FAIL_FS_TYPE, FAIL_FS_CORRUPT, FAIL_FULL, FAIL_ROOT_FULL, FAIL_CARD_TYPE
  } fail_t;

endpackage
`default_nettype wire

/* common/word_buf_if.sv */
// Valid/ready word channel between the manager and its buffer
`timescale 1ns/1ns
`default_nettype none

interface word_buf_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

/* src/sd_logger_card_manager.sv */
// Card manager: insertion, eject, format, LED patterns and the stored data path
`timescale 1ns/1ns
`default_nettype none
`include "card_mgr_cfg.svh"

// Notes on behaviour
// - Short press while storing: stop, close files, flash rapidly, then LED off.
// - After eject completes, raise the remove-card prompt for an attached display.
// - Card still in 10 s after eject: reinitialise and resume storing.
// - Storage off or init failed: card may leave anytime, no eject needed.
// - Card present at power-up: start initialisation a few seconds later, unprompted.
// - Button held while card enters empty slot: format; two flashes, then release.
// - During formatting the LED repeats a double blink.
// - Format success: initialise with rapid flashing, then store with LED steady.
// - Format failure: slow blinking, another card is needed.
// - Initialised, storage off: one short blink every 3 seconds.
// - Initialised, storage on: LED lit steadily.
// - Initialisation failed: slow blinking while the card stays inserted.
// - Init fails on bad or corrupt FS, full card, over 512 root entries, bad card.
// - Measurement words reach the card as binary words, unaltered.
// - Rapid flashing during card verification and initialisation.
// - FAT16, clusters of at most 64kB, space above the limit unused.
// - Storage-enabled setting survives a power cycle.
module sd_logger_card_manager #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2,
  parameter int TICK_CYC = `TICK_MS * (`CLK_HZ / 1000)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic card_present,
  input wire logic button_pressed,
  input wire logic storage_on,
  output card_mgr_pkg::cmd_t card_cmd,
  input wire logic cmd_done,
  input wire logic cmd_fail,
  input wire logic fs_unsupported,
  input wire logic fs_corrupt,
  input wire logic card_full,
  input wire logic [15:0] root_entries,
  input wire logic [31:0] card_sectors,
  output logic [31:0] usable_sectors,
  output logic [7:0] cluster_sectors,
  output card_mgr_pkg::fail_t fail_cause,
  output logic storing,
  output logic remove_card_prompt,
  output logic led_on,
  input wire logic meas_valid,
  output logic meas_ready,
  input wire logic [WIDTH-1:0] meas_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [WIDTH-1:0] wr_data
);
  import card_mgr_pkg::*;

  // ****************************************
  // Timing
  // ****************************************
  localparam int PWRUP_TICKS = `PWRUP_MS / `TICK_MS;
  localparam int RESUME_TICKS = `RESUME_MS / `TICK_MS;
  localparam int EJECT_TICKS = `EJECT_FLASH_MS / `TICK_MS;
  localparam int FRAME_CNT = `IDLE_FRAME_MS / (`TICK_MS * `BLINK_FRAME_TICKS);
  state_t state_q, state_d;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [7:0] timer_q;
  logic [3:0] phase_q;
  logic [3:0] frame_q;
  logic btn_q;
  logic press;
  logic close_done_q;
  logic init_bad;
  logic rapid_w, slow_w, double_w, single_w;
  logic flow;
  fail_t fail_q;
  logic led_q;
  logic [31:0] usable_q;

  assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));
  assign press = button_pressed && !btn_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h1;
    end
  end

  // Free-running blink phase, shared so the rapid, slow, double and single patterns stay in step
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phase_q <= '0;
      frame_q <= '0;
    end else if (tick) begin
      if (phase_q == 4'(`BLINK_FRAME_TICKS - 1)) begin
        phase_q <= '0;
        frame_q <= (frame_q == 4'(FRAME_CNT - 1)) ? '0 : frame_q + 4'h1;
      end else begin
        phase_q <= phase_q + 4'h1;
      end
    end
  end

  assign rapid_w = phase_q[0];
  assign slow_w = (phase_q < 4'(`SLOW_ON_TICKS));
  assign double_w = (phase_q == 4'h0) || (phase_q == 4'h2);
  assign single_w = (phase_q == 4'h0) && (frame_q == 4'h0);

  // Ticks spent in the current state; restarts on every transition
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      timer_q <= '0;
    end else if (state_d != state_q) begin
      timer_q <= '0;
    end else if (tick && timer_q != 8'hFF) begin
      timer_q <= timer_q + 8'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      btn_q <= 1'b0;
    end else begin
      btn_q <= button_pressed;
    end
  end

  // ****************************************
  // Card state machine
  // ****************************************
  assign init_bad = fs_unsupported || fs_corrupt || card_full
                    || (root_entries > 16'(`ROOT_MAX_ENTRIES));
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_PWRUP: begin
        if (tick && timer_q >= 8'(PWRUP_TICKS - 1)) begin
          state_d = card_present ? ST_INIT : ST_NOCARD;
        end
      end
      ST_NOCARD: begin
        if (card_present) begin
          state_d = button_pressed ? ST_FMT_ACK : ST_INIT;
        end
      end
      ST_FMT_ACK: begin
        if (tick && timer_q == 8'(`ACK_TICKS - 1)) begin
          state_d = ST_FMT_REL;
        end
      end
      ST_FMT_REL: begin
        if (!button_pressed) begin
          state_d = ST_FORMAT;
        end
      end
      ST_FORMAT: begin
        if (cmd_fail) begin
          state_d = ST_FMT_FAIL;
        end else if (cmd_done) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (cmd_fail || (cmd_done && init_bad)) begin
          state_d = ST_INIT_FAIL;
        end else if (cmd_done) begin
          state_d = ST_READY;
        end
      end
      ST_READY: begin
        if (press && storage_on) begin
          state_d = ST_EJECT_CLOSE;
        end
      end
      ST_EJECT_CLOSE: begin
        if (close_done_q && timer_q >= 8'(EJECT_TICKS)) begin
          state_d = ST_EJECTED;
        end
      end
      ST_EJECTED: begin
        if (tick && timer_q == 8'(RESUME_TICKS - 1)) begin
          state_d = ST_INIT;
        end
      end
      ST_FMT_FAIL, ST_INIT_FAIL: state_d = state_q;
      default: begin
        state_d = ST_NOCARD;
      end
    endcase
    // Withdrawal is always tolerated; only the storing and eject-close states risk data
    if (!card_present && state_q != ST_PWRUP) begin
      state_d = ST_NOCARD;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= ST_PWRUP;
    end else begin
      state_q <= state_d;
    end
  end

  // Close is held back until the buffer has drained to the card
  always_comb begin
    case (state_q)
      ST_INIT: card_cmd = CMD_INIT;
      ST_FORMAT: card_cmd = CMD_FORMAT;
      ST_EJECT_CLOSE: card_cmd = (close_done_q || wr_valid) ? CMD_NONE : CMD_CLOSE;
      default: card_cmd = CMD_NONE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      close_done_q <= 1'b0;
    end else if (state_q != ST_EJECT_CLOSE) begin
      close_done_q <= 1'b0;
    end else if (cmd_done && card_cmd == CMD_CLOSE) begin
      close_done_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fail_q <= FAIL_NONE;
    end else if (state_q != ST_INIT && state_d == ST_INIT) begin
      fail_q <= FAIL_NONE;
    end else if (state_q == ST_INIT && cmd_fail) begin
      fail_q <= FAIL_CARD_TYPE;
    end else if (state_q == ST_INIT && cmd_done) begin
      if (fs_unsupported) begin
        fail_q <= FAIL_FS_TYPE;
      end else if (fs_corrupt) begin
        fail_q <= FAIL_FS_CORRUPT;
      end else if (card_full) begin
        fail_q <= FAIL_FULL;
      end else if (root_entries > 16'(`ROOT_MAX_ENTRIES)) begin
        fail_q <= FAIL_ROOT_FULL;
      end
    end
  end

  // Sectors past the FAT16 reach are simply left unused
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      usable_q <= `SECTORS_RESET;
    end else if (!card_present) begin
      usable_q <= `SECTORS_RESET;
    end else begin
      usable_q <= (card_sectors > `FAT16_MAX_SECTORS) ? `FAT16_MAX_SECTORS
                                                      : card_sectors;
    end
  end

  assign usable_sectors = usable_q;
  assign cluster_sectors = `CLUSTER_MAX_SECTORS;
  assign fail_cause = fail_q;

  // ****************************************
  // LED
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      led_q <= 1'b0;
    end else begin
      case (state_q)
        ST_FMT_ACK: led_q <= !timer_q[0] && timer_q < 8'(`ACK_TICKS);
        ST_FORMAT: led_q <= double_w;
        ST_FMT_FAIL: led_q <= slow_w;
        ST_INIT: led_q <= rapid_w;
        ST_INIT_FAIL: led_q <= slow_w;
        ST_READY: led_q <= storage_on ? 1'b1 : single_w;
        ST_EJECT_CLOSE: led_q <= rapid_w;
        default: led_q <= 1'b0;
      endcase
    end
  end

  assign led_on = led_q;
  assign remove_card_prompt = (state_q == ST_EJECTED);

  // ****************************************
  // Data path
  // ****************************************
  // storage_on comes from the retained setting, so a power cycle keeps it
  assign storing = (state_q == ST_READY) && storage_on;
  assign flow = storing || (state_q == ST_EJECT_CLOSE);

  word_buf_if #(.WIDTH(WIDTH)) fill_if ();
  word_buf_if #(.WIDTH(WIDTH)) drain_if ();

  assign fill_if.valid = meas_valid && storing;
  assign fill_if.data = meas_data;
  assign meas_ready = fill_if.ready && storing;
  assign wr_valid = drain_if.valid && flow;
  assign wr_data = drain_if.data;
  assign drain_if.ready = wr_ready && flow;

  word_buf #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .fill(fill_if),
    .drain(drain_if)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // A press while already ejecting is a legal repeat and is left out here
  property p_eject_only_storing;
    press && state_q != ST_EJECT_CLOSE && !(state_q == ST_READY && storage_on)
      |=> state_q != ST_EJECT_CLOSE;
  endproperty
  a_eject_only_storing: assert property (p_eject_only_storing) else $error("eject outside storing");
  property p_eject_flash;
    state_q == ST_EJECT_CLOSE |=> led_q == $past(rapid_w);
  endproperty
  a_eject_flash: assert property (p_eject_flash) else $error("no rapid flash during eject");
  property p_resume;
    state_q == ST_EJECTED && card_present && tick && timer_q == 8'(RESUME_TICKS - 1)
      |=> state_q == ST_INIT;
  endproperty
  a_resume: assert property (p_resume) else $error("card not resumed after wait");
  property p_removal;
    !card_present && state_q != ST_PWRUP |=> state_q == ST_NOCARD ##1 !led_q;
  endproperty
  a_removal: assert property (p_removal) else $error("removal not handled");
  property p_steady;
    (state_q == ST_READY && storage_on) [*2] |=> led_q;
  endproperty
  a_steady: assert property (p_steady) else $error("LED not steady while storing");
  // The LED register still holds the last flash in the first prompt cycle
  property p_prompt;
    remove_card_prompt |-> state_q == ST_EJECTED && card_cmd == CMD_NONE
      && (!led_q || !$past(remove_card_prompt));
  endproperty
  a_prompt: assert property (p_prompt) else $error("prompt without finished eject");
  property p_root_full;
    state_q == ST_INIT && cmd_done && card_present && root_entries > 16'(`ROOT_MAX_ENTRIES)
      |=> state_q == ST_INIT_FAIL;
  endproperty
  a_root_full: assert property (p_root_full) else $error("root overflow not failed");
  property p_fail_slow;
    state_q == ST_INIT_FAIL |=> led_q == $past(slow_w);
  endproperty
  a_fail_slow: assert property (p_fail_slow) else $error("failed card not slow blink");
  property p_fmt_entry;
    state_q == ST_NOCARD && card_present && button_pressed |=> state_q == ST_FMT_ACK;
  endproperty
  a_fmt_entry: assert property (p_fmt_entry) else $error("format not entered");
  property p_hold_data;
    wr_valid && !wr_ready && flow |=> $stable(wr_data);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("word changed while stalled");
  c_eject: cover property (state_q == ST_EJECTED ##1 state_q == ST_INIT);
  c_format: cover property (state_q == ST_FORMAT ##1 state_q == ST_INIT);
  c_init_fail: cover property (state_q == ST_INIT ##1 state_q == ST_INIT_FAIL);
  c_stall: cover property (wr_valid && !wr_ready && !meas_ready);

endmodule

`default_nettype wire

/* src/word_buf.sv */
// Small FIFO buffer in the measurement data path
`timescale 1ns/1ns
`default_nettype none

module word_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  word_buf_if.snk fill,
  word_buf_if.src drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  assign fill.ready = (count_q != CW'(DEPTH));
  assign drain.valid = (count_q != '0);
  assign drain.data = mem[rd_ptr_q];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_q] <= fill.data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end

  property p_no_overrun;
    @(posedge clk_sys) disable iff (reset)
    count_q == CW'(DEPTH) && !pop |=> count_q == CW'(DEPTH);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("buffer count moved while full");

endmodule

`default_nettype wire

/* verif/card_ctrl_model.sv */
// Behavioural card controller and card writer facing the card manager
`timescale 1ns/1ns
`default_nettype none

module card_ctrl_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire card_mgr_pkg::cmd_t card_cmd,
  input wire logic [9:0] lat,
  input wire logic fail_now,
  input wire logic stall,
  output logic cmd_done,
  output logic cmd_fail,
  output logic wr_ready
);
  import card_mgr_pkg::*;
  cmd_t last_q;
  logic [9:0] cnt_q;
  logic sent_q;

  // Writer stalls only when the bench asks, so buffer backpressure is reachable
  assign wr_ready = !stall;

  // One answer per standing command, lat + 2 cycles after it appears
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      last_q <= CMD_NONE;
      cnt_q <= 10'h000;
      sent_q <= 1'b0;
      cmd_done <= 1'b0;
      cmd_fail <= 1'b0;
    end else begin
      last_q <= card_cmd;
      cmd_done <= 1'b0;
      cmd_fail <= 1'b0;
      if (card_cmd == CMD_NONE || card_cmd != last_q) begin
        cnt_q <= 10'h000;
        sent_q <= 1'b0;
      end else if (!sent_q && cnt_q >= lat) begin
        cmd_done <= !fail_now;
        cmd_fail <= fail_now;
        sent_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 10'h001;
      end
    end
  end
endmodule

`default_nettype wire

/* verif/sd_logger_card_manager_tb.sv */
// Self-checking bench for the card manager
`timescale 1ns/1ns
`default_nettype none

module sd_logger_card_manager_tb;
  import card_mgr_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic card_present = 1'b1;
  logic button_pressed = 1'b0;
  logic storage_on = 1'b1;
  logic fs_unsupported = 1'b0;
  logic fs_corrupt = 1'b0;
  logic card_full = 1'b0;
  logic [15:0] root_entries = 16'h0000;
  logic [31:0] card_sectors = 32'h0100_0000;
  logic meas_valid = 1'b0;
  logic [31:0] meas_data = 32'h0000_0000;
  logic [9:0] lat = 10'h064;
  logic fail_now = 1'b0;
  logic stall = 1'b0;
  cmd_t card_cmd;
  fail_t fail_cause;
  logic cmd_done, cmd_fail, storing, remove_card_prompt, led_on, meas_ready, wr_valid, wr_ready;
  logic [31:0] usable_sectors;
  logic [31:0] wr_data;
  logic [7:0] cluster_sectors;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int tg;
  int hi;
  fail_t exp_cause[6] = '{FAIL_FS_TYPE, FAIL_FS_CORRUPT, FAIL_FULL, FAIL_ROOT_FULL,
    FAIL_CARD_TYPE, FAIL_NONE};

  always #20 clk_sys = ~clk_sys;

  sd_logger_card_manager #(.TICK_CYC(4)) DUT (
    .clk_sys(clk_sys), .reset(reset), .card_present(card_present),
    .button_pressed(button_pressed), .storage_on(storage_on), .card_cmd(card_cmd),
    .cmd_done(cmd_done), .cmd_fail(cmd_fail), .fs_unsupported(fs_unsupported),
    .fs_corrupt(fs_corrupt), .card_full(card_full), .root_entries(root_entries),
    .card_sectors(card_sectors), .usable_sectors(usable_sectors),
    .cluster_sectors(cluster_sectors), .fail_cause(fail_cause), .storing(storing),
    .remove_card_prompt(remove_card_prompt), .led_on(led_on), .meas_valid(meas_valid),
    .meas_ready(meas_ready), .meas_data(meas_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data)
  );

  card_ctrl_model partner (
    .clk_sys(clk_sys), .reset(reset), .card_cmd(card_cmd), .lat(lat), .fail_now(fail_now),
    .stall(stall), .cmd_done(cmd_done), .cmd_fail(cmd_fail), .wr_ready(wr_ready)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Run is under 2500 cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cmd(input cmd_t c, input int lim);
    int i;
    for (i = 0; i < lim && card_cmd !== c; i++) @(negedge clk_sys);
    check(card_cmd, c);
  endtask

  // Whole pattern periods give exact counts whatever the start phase
  task automatic led_stats(input int n);
    logic prev;
    prev = led_on;
    tg = 0;
    hi = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (led_on !== prev) tg++;
      if (led_on === 1'b1) hi++;
      prev = led_on;
    end
  endtask

  task automatic settle_ready;
    wait_cmd(CMD_NONE, 20);
    repeat (4) @(negedge clk_sys);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_powerup;
    repeat (90) @(negedge clk_sys);
    check(card_cmd, CMD_NONE);
    wait_cmd(CMD_INIT, 60);
    repeat (4) @(negedge clk_sys);
    led_stats(80);
    check(tg, 20);
    lat = 10'h003;
    settle_ready();
    check(storing, 1'b1);
    led_stats(40);
    check(hi, 40);
    check(usable_sectors, 32'h0080_0000);
    check(cluster_sectors, 8'h80);
    $display("test powerup done");
  endtask

  task automatic t_stream;
    logic [31:0] w[3];
    int acc;
    int got;
    w = '{32'hA5A5_0001, 32'h5A5A_0002, 32'hFFFF_0003};
    acc = 0;
    got = 0;
    stall = 1'b1;
    repeat (8) begin
      @(negedge clk_sys);
      meas_valid = (acc < 3);
      meas_data = w[acc % 3];
      if (meas_ready === 1'b1 && acc < 3) acc++;
    end
    check(acc, 2);
    // Stall is lifted only after the head word has been seen
    repeat (12) begin
      @(negedge clk_sys);
      if (wr_valid === 1'b1 && got < 3) begin
        check(wr_data, w[got]);
        got++;
      end
      stall = 1'b0;
      meas_valid = (acc < 3);
      meas_data = w[acc % 3];
      if (meas_ready === 1'b1 && acc < 3) acc++;
    end
    check(got, 3);
    $display("test stream done");
  endtask

  task automatic t_eject;
    button_pressed = 1'b1;
    @(negedge clk_sys);
    button_pressed = 1'b0;
    wait_cmd(CMD_CLOSE, 10);
    repeat (4) @(negedge clk_sys);
    led_stats(40);
    check(tg, 10);
    for (int i = 0; i < 80 && remove_card_prompt !== 1'b1; i++) @(negedge clk_sys);
    check(remove_card_prompt, 1'b1);
    // LED register lags the state by one cycle
    @(negedge clk_sys);
    check(led_on, 1'b0);
    repeat (360) @(negedge clk_sys);
    check(card_cmd, CMD_NONE);
    wait_cmd(CMD_INIT, 60);
    settle_ready();
    check(storing, 1'b1);
    $display("test eject done");
  endtask

  task automatic t_off;
    storage_on = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(storing, 1'b0);
    led_stats(240);
    check(tg, 4);
    check(hi, 8);
    button_pressed = 1'b1;
    repeat (8) @(negedge clk_sys);
    check(card_cmd, CMD_NONE);
    check(remove_card_prompt, 1'b0);
    button_pressed = 1'b0;
    card_present = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(led_on, 1'b0);
    check(usable_sectors, 32'h0000_0000);
    check(card_cmd, CMD_NONE);
    storage_on = 1'b1;
    $display("test storage off done");
  endtask

  task automatic t_init_fail(input int i);
    fs_unsupported = (i == 0);
    fs_corrupt = (i == 1);
    card_full = (i == 2);
    root_entries = (i == 3) ? 16'h0201 : 16'h0200;
    fail_now = (i == 4);
    card_present = 1'b1;
    wait_cmd(CMD_INIT, 10);
    settle_ready();
    check(fail_cause, exp_cause[i]);
    led_stats(80);
    check(tg, (i == 5) ? 0 : 4);
    card_present = 1'b0;
    fail_now = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(led_on, 1'b0);
    $display("test init fail %0d done", i);
  endtask

  task automatic t_format(input logic f);
    button_pressed = 1'b1;
    repeat (2) @(negedge clk_sys);
    card_present = 1'b1;
    led_stats(40);
    check(tg, 4);
    check(card_cmd, CMD_NONE);
    lat = 10'h0C8;
    fail_now = f;
    button_pressed = 1'b0;
    wait_cmd(CMD_FORMAT, 10);
    repeat (4) @(negedge clk_sys);
    led_stats(80);
    check(tg, 8);
    lat = 10'h003;
    if (f) begin
      settle_ready();
      led_stats(80);
      check(tg, 4);
      check(storing, 1'b0);
    end else begin
      wait_cmd(CMD_INIT, 20);
      settle_ready();
      check(storing, 1'b1);
      led_stats(40);
      check(hi, 40);
    end
    card_present = 1'b0;
    fail_now = 1'b0;
    repeat (4) @(negedge clk_sys);
    $display("test format %0d done", f);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    t_powerup();
    t_stream();
    t_eject();
    t_off();
    for (int i = 0; i < 6; i++) t_init_fail(i);
    t_format(1'b0);
    t_format(1'b1);
    conclude();
  end
endmodule

`default_nettype wire
